// File: rtl/fifo_access_pkg.sv
// Purpose: constants used by the indirect fifo access port, not by its word engine
// Assumes: byte-wide mcu data bus with a 16-bit address
// Notes:   word address is 13 bits, memory words are 32 bits
package fifo_access_pkg;
  localparam int          ADDR_W          = 13;
  localparam int          WORD_W          = 32;
  // register offsets on the mcu data bus
  localparam logic [15:0] OFS_DATA_BYTE0  = 16'hf0e0;
  localparam logic [15:0] OFS_DATA_BYTE1  = 16'hf0e1;
  localparam logic [15:0] OFS_DATA_BYTE2  = 16'hf0e2;
  localparam logic [15:0] OFS_DATA_BYTE3  = 16'hf0e3;
  localparam logic [15:0] OFS_ADDR_LOW    = 16'hf0e4;
  localparam logic [15:0] OFS_ADDR_HIGH   = 16'hf0e5;
  // high address / control register fields
  localparam int          HIGH_ADDR_LSB   = 0;
  localparam int          HIGH_ADDR_MSB   = 4;
  localparam int          HIGH_RESERVED_BIT = 5;
  localparam int          HIGH_BUSY_BIT   = 6;
  localparam int          HIGH_DIR_BIT    = 7;
  // reset values
  localparam logic [7:0]  RST_DATA_BYTE   = 8'h00;
  localparam logic [7:0]  RST_ADDR_LOW    = 8'h00;
  localparam logic [4:0]  RST_ADDR_HIGH   = 5'h00;
  localparam logic        RST_BUSY        = 1'b0;
  localparam logic        RST_DIR         = 1'b0;
  localparam logic        RESERVED_BIT_VALUE = 1'b0;
  localparam logic [7:0]  UNMAPPED_VALUE  = 8'h00;
  // direction encoding
  localparam logic        DIR_WRITE       = 1'b0;
  localparam logic        DIR_READ        = 1'b1;
  // word address step after each transferred word
  localparam logic [12:0] ADDR_STEP       = 13'h0001;
endpackage

// File: rtl/fifo_cmd_if.sv
// Purpose: carries word commands between register logic and word engine
// Assumes: single clock domain
// Notes:   start and done are one-cycle pulses
`timescale 1ns/10ps
interface fifo_cmd_if;
  logic        start;
  logic        write_op;
  logic [12:0] addr;
  logic [31:0] wdata;
  logic        done;
  logic [31:0] rdata;
  modport regs   (output start, output write_op, output addr, output wdata,
                  input done, input rdata);
  modport engine (input start, input write_op, input addr, input wdata,
                  output done, output rdata);
endinterface

// File: rtl/fifo_word_engine.sv
// Purpose: runs one 32-bit read or write against sector fifo memory
// Assumes: memory holds mem_ack high for one cycle per request
// Notes:   all memory-side outputs are registered
`timescale 1ns/10ps
module fifo_word_engine (
  input  wire logic        clk,
  input  wire logic        reset,
  fifo_cmd_if.engine       cmd,
  output logic             mem_req,
  output logic             mem_we,
  output logic [12:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata
);
  typedef enum logic {ENG_IDLE, ENG_WAIT} eng_state_t;
  eng_state_t state_q;

  ////////////////////////////////////////////////////////////////////////
  // request sequencing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q   <= ENG_IDLE;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
    end else begin
      case (state_q)
        ENG_IDLE: begin
          if (cmd.start) begin
            state_q   <= ENG_WAIT;
            mem_req   <= 1'b1;
            mem_we    <= cmd.write_op;
            mem_addr  <= cmd.addr;
            mem_wdata <= cmd.wdata;
          end
        end
        ENG_WAIT: begin
          if (mem_ack) begin
            state_q <= ENG_IDLE;
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
          end
        end
        default: state_q <= ENG_IDLE;
      endcase
    end
  end

  // completion pulse and captured read word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd.done  <= 1'b0;
      cmd.rdata <= '0;
    end else begin
      cmd.done <= (state_q == ENG_WAIT) && mem_ack;
      if ((state_q == ENG_WAIT) && mem_ack && !mem_we) begin
        cmd.rdata <= mem_rdata;
      end
    end
  end
endmodule

// File: rtl/fifo_access_port.sv
// Purpose: mcu indirect access port into the sector fifo memory
// Assumes: mcu data bus strobes are synchronous to clk, one cycle each
// Notes:   read data answers one cycle after the read strobe
`timescale 1ns/10ps

module fifo_access_port (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [15:0] xaddr,
  input  wire logic [7:0]  xwdata,
  input  wire logic        xwr,
  input  wire logic        xrd,
  output logic      [7:0]  xrdata_q,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [12:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata
);
  fifo_cmd_if cmd ();

  logic [7:0]  data_byte_q [4];
  logic [12:0] fifo_word_address_q;
  logic        fifo_access_in_progress_q;
  logic        fifo_access_direction_q;
  logic        start_q;
  logic        write_op_q;
  logic        wr_byte_en [4];
  logic        wr_low;
  logic        wr_high;
  logic        rd_byte3;
  logic        start_d;
  logic        write_op_d;

  ////////////////////////////////////////////////////////////////////////
  // bus decode; data and address writes are dropped while busy
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_byte_en[i] = 1'b0;
    end
    wr_low   = 1'b0;
    wr_high  = 1'b0;
    rd_byte3 = 1'b0;
    if (xwr && !fifo_access_in_progress_q) begin
      if (xaddr == fifo_access_pkg::OFS_DATA_BYTE0) begin
        wr_byte_en[0] = 1'b1;
      end else if (xaddr == fifo_access_pkg::OFS_DATA_BYTE1) begin
        wr_byte_en[1] = 1'b1;
      end else if (xaddr == fifo_access_pkg::OFS_DATA_BYTE2) begin
        wr_byte_en[2] = 1'b1;
      end else if (xaddr == fifo_access_pkg::OFS_DATA_BYTE3) begin
        wr_byte_en[3] = 1'b1;
      end else if (xaddr == fifo_access_pkg::OFS_ADDR_LOW) begin
        wr_low = 1'b1;
      end else if (xaddr == fifo_access_pkg::OFS_ADDR_HIGH) begin
        wr_high = 1'b1;
      end
    end
    if (xrd && !fifo_access_in_progress_q && (xaddr == fifo_access_pkg::OFS_DATA_BYTE3)) begin
      rd_byte3 = 1'b1;
    end
  end

  // word command triggers
  always_comb begin
    start_d    = 1'b0;
    write_op_d = 1'b0;
    if (wr_high && xwdata[fifo_access_pkg::HIGH_DIR_BIT]) begin
      start_d = 1'b1;
    end else if (wr_byte_en[3] && (fifo_access_direction_q == fifo_access_pkg::DIR_WRITE)) begin
      start_d    = 1'b1;
      write_op_d = 1'b1;
    end else if (rd_byte3 && (fifo_access_direction_q == fifo_access_pkg::DIR_READ)) begin
      start_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data byte registers: mcu writes or word loaded by a prefetch
  generate
    for (genvar b = 0; b < 4; b++) begin : g_byte
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          data_byte_q[b] <= fifo_access_pkg::RST_DATA_BYTE;
        end else if (cmd.done && !write_op_q) begin
          data_byte_q[b] <= cmd.rdata[8*b +: 8];
        end else if (wr_byte_en[b]) begin
          data_byte_q[b] <= xwdata;
        end
      end
    end
  endgenerate

  // word address: mcu writes or post-increment after each word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fifo_word_address_q <= {fifo_access_pkg::RST_ADDR_HIGH, fifo_access_pkg::RST_ADDR_LOW};
    end else if (cmd.done) begin
      fifo_word_address_q <= fifo_word_address_q + fifo_access_pkg::ADDR_STEP;
    end else if (wr_low) begin
      fifo_word_address_q[7:0] <= xwdata;
    end else if (wr_high) begin
      fifo_word_address_q[12:8] <= xwdata[fifo_access_pkg::HIGH_ADDR_MSB:
                                          fifo_access_pkg::HIGH_ADDR_LSB];
    end
  end

  // direction flag
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fifo_access_direction_q <= fifo_access_pkg::RST_DIR;
    end else if (wr_high) begin
      fifo_access_direction_q <= xwdata[fifo_access_pkg::HIGH_DIR_BIT];
    end
  end

  // busy flag: set by a started word, cleared on completion only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fifo_access_in_progress_q <= fifo_access_pkg::RST_BUSY;
    end else if (start_d) begin
      fifo_access_in_progress_q <= 1'b1;
    end else if (cmd.done) begin
      fifo_access_in_progress_q <= 1'b0;
    end
  end

  // command pulse to the word engine
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      start_q    <= 1'b0;
      write_op_q <= 1'b0;
    end else begin
      start_q <= start_d;
      if (start_d) begin
        write_op_q <= write_op_d;
      end
    end
  end

  assign cmd.start    = start_q;
  assign cmd.write_op = write_op_q;
  assign cmd.addr     = fifo_word_address_q;
  assign cmd.wdata    = {data_byte_q[3], data_byte_q[2], data_byte_q[1], data_byte_q[0]};

  ////////////////////////////////////////////////////////////////////////
  // registered read data, unmapped offsets read as zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xrdata_q <= fifo_access_pkg::UNMAPPED_VALUE;
    end else if (xrd) begin
      if (xaddr == fifo_access_pkg::OFS_DATA_BYTE0) begin
        xrdata_q <= data_byte_q[0];
      end else if (xaddr == fifo_access_pkg::OFS_DATA_BYTE1) begin
        xrdata_q <= data_byte_q[1];
      end else if (xaddr == fifo_access_pkg::OFS_DATA_BYTE2) begin
        xrdata_q <= data_byte_q[2];
      end else if (xaddr == fifo_access_pkg::OFS_DATA_BYTE3) begin
        xrdata_q <= data_byte_q[3];
      end else if (xaddr == fifo_access_pkg::OFS_ADDR_LOW) begin
        xrdata_q <= fifo_word_address_q[7:0];
      end else if (xaddr == fifo_access_pkg::OFS_ADDR_HIGH) begin
        xrdata_q <= {fifo_access_direction_q, fifo_access_in_progress_q,
                     fifo_access_pkg::RESERVED_BIT_VALUE, fifo_word_address_q[12:8]};
      end else begin
        xrdata_q <= fifo_access_pkg::UNMAPPED_VALUE;
      end
    end
  end

  fifo_word_engine u_engine (
    .clk       (clk),
    .reset     (reset),
    .cmd       (cmd),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_BYTE3_WRITE: assert property (@(posedge clk) disable iff (reset)
    wr_byte_en[3] && !fifo_access_direction_q |=> data_byte_q[3] == $past(xwdata))
    else $error("data byte 3 did not take the written value");
  AST_ADDR_LOW_WRITE: assert property (@(posedge clk) disable iff (reset)
    wr_low |=> fifo_word_address_q[7:0] == $past(xwdata))
    else $error("low address byte did not take the written value");
  AST_HIGH_READBACK: assert property (@(posedge clk) disable iff (reset)
    xrd && xaddr == fifo_access_pkg::OFS_ADDR_HIGH |=>
      xrdata_q[5] == 1'b0 && xrdata_q[4:0] == $past(fifo_word_address_q[12:8])
      && xrdata_q[6] == $past(fifo_access_in_progress_q))
    else $error("high register readback wrong");
  AST_BUSY_DURING_REQ: assert property (@(posedge clk) disable iff (reset)
    mem_req |-> fifo_access_in_progress_q)
    else $error("memory request without busy");
  AST_BUSY_HOLDS: assert property (@(posedge clk) disable iff (reset)
    fifo_access_in_progress_q && !cmd.done |=> fifo_access_in_progress_q)
    else $error("busy dropped before completion");
  AST_DIR_WRITE: assert property (@(posedge clk) disable iff (reset)
    wr_high |=> fifo_access_direction_q == $past(xwdata[7]))
    else $error("direction flag did not follow the write");
  AST_PREFETCH_START: assert property (@(posedge clk) disable iff (reset)
    wr_high && xwdata[7] |-> ##2 mem_req && !mem_we)
    else $error("prefetch did not start after high write in read direction");
  AST_COMMIT_START: assert property (@(posedge clk) disable iff (reset)
    wr_byte_en[3] && !fifo_access_direction_q |-> ##2
      mem_req && mem_we && mem_wdata[31:24] == $past(xwdata, 2))
    else $error("word commit did not start after byte 3 write");
  AST_DONE_STEP: assert property (@(posedge clk) disable iff (reset)
    cmd.done |=> !fifo_access_in_progress_q
      && fifo_word_address_q == $past(fifo_word_address_q) + 13'h0001)
    else $error("completion did not clear busy and step the address");
  AST_NO_EARLY_PREFETCH: assert property (@(posedge clk) disable iff (reset)
    fifo_access_direction_q && !fifo_access_in_progress_q && !rd_byte3 && !wr_high
      && !wr_byte_en[3] |=> !fifo_access_in_progress_q)
    else $error("prefetch started without a byte 3 read");
endmodule

// File: dv/fifo_mem_model.sv
// Purpose: sector fifo memory seen from the word engine side
// Assumes: one request outstanding, ack answers one request
// Notes:   slow adds four wait cycles; idle read data toggles
`timescale 1ns/10ps
module fifo_mem_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [12:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata
);
  logic [31:0] mem [0:8191];
  logic [2:0]  wait_q;

  // preload a pattern that carries the word address
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 32'ha5c30000 | i;
    end
  end

  // one ack pulse per request; rdata is junk outside the ack cycle
  // plain always: the preload above also writes mem
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_ack   <= 1'b0;
      wait_q    <= 3'h0;
      mem_rdata <= 32'h00000000;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (wait_q == (slow ? 3'h4 : 3'h0)) begin
          mem_ack <= 1'b1;
          wait_q  <= 3'h0;
          if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
          end else begin
            mem_rdata <= mem[mem_addr];
          end
        end else begin
          wait_q <= wait_q + 3'h1;
        end
      end
    end
  end
endmodule

// File: dv/tb_fifo_access_port.sv
// Purpose: register level tests of the mcu fifo access port
// Assumes: one strobe per access, read data one cycle after xrd
// Notes:   memory contents peeked in the partner model
`timescale 1ns/10ps
module tb_fifo_access_port;
  logic        clk;
  logic        reset;
  logic [15:0] xaddr;
  logic [7:0]  xwdata;
  logic        xwr;
  logic        xrd;
  logic [7:0]  xrdata_q;
  logic        mem_req;
  logic        mem_we;
  logic [12:0] mem_addr;
  logic [31:0] mem_wdata;
  logic        mem_ack;
  logic [31:0] mem_rdata;
  logic        slow;
  int          bad_count;
  int          cmp_count;

  fifo_access_port fifo_access_port_inst (.clk(clk), .reset(reset), .xaddr(xaddr),
    .xwdata(xwdata), .xwr(xwr), .xrd(xrd), .xrdata_q(xrdata_q), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  fifo_mem_model fifo_mem_model_inst (.clk(clk), .reset(reset), .slow(slow),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare, report and finish
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // mcu bus accesses
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    xaddr  <= a;
    xwdata <= d;
    xwr    <= 1'b1;
    @(posedge clk);
    xwr    <= 1'b0;
  endtask

  task automatic rd_raw(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    xaddr <= a;
    xrd   <= 1'b1;
    @(posedge clk);
    xrd   <= 1'b0;
    #1 v = xrdata_q;
  endtask

  task automatic rd(input string name, input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd_raw(a, v);
    chk(name, {24'h0, v}, {24'h0, exp});
  endtask

  // wait for the busy flag to drop, bounded
  task automatic poll();
    logic [7:0] v;
    int         n;
    v = 8'h40;
    n = 0;
    while (v[6] !== 1'b0 && n < 100) begin
      rd_raw(16'hf0e5, v);
      n++;
    end
    chk("busy poll", {31'h0, v[6]}, 32'h0);
  endtask

  // read one prefetched word byte 0 first, byte 3 last
  task automatic read_word(input logic [12:0] a);
    logic [31:0] w;
    w = 32'ha5c30000 | a;
    for (int i = 0; i < 4; i++) begin
      rd("data byte", 16'hf0e0 + i, w[8*i +: 8]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    bad_count = 0;
    cmp_count = 0;
    reset = 1'b1;
    xaddr = 16'h0000;
    xwdata = 8'h00;
    xwr = 1'b0;
    xrd = 1'b0;
    slow = 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    // reset values, unmapped place included
    for (int i = 0; i < 7; i++) begin
      rd("reset value", 16'hf0e0 + i, 8'h00);
    end
    $display("test reset done");
    // write word at top address, busy, refused write, wrap
    wr(16'hf0e4, 8'hff);
    wr(16'hf0e5, 8'h1f);
    for (int i = 0; i < 4; i++) begin
      wr(16'hf0e0 + i, 8'h11 * (i + 1));
    end
    rd("busy on commit", 16'hf0e5, 8'h5f);
    wr(16'hf0e4, 8'h77);
    poll();
    chk("mem word", fifo_mem_model_inst.mem[13'h1fff], 32'h44332211);
    rd("addr low", 16'hf0e4, 8'h00);
    rd("addr high", 16'hf0e5, 8'h00);
    slow <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(16'hf0e0 + i, 8'ha1 + i);
    end
    poll();
    chk("mem word", fifo_mem_model_inst.mem[13'h0000], 32'ha4a3a2a1);
    rd("addr low", 16'hf0e4, 8'h01);
    rd("byte3", 16'hf0e3, 8'ha4);
    $display("test write done");
    // busy and reserved bits ignore writes
    wr(16'hf0e5, 8'h7f);
    rd("high ctrl", 16'hf0e5, 8'h1f);
    // read direction with prefetch
    slow <= 1'b1;
    wr(16'hf0e4, 8'h10);
    wr(16'hf0e5, 8'h80);
    rd("busy on fetch", 16'hf0e5, 8'hc0);
    poll();
    rd("addr step", 16'hf0e4, 8'h11);
    read_word(13'h0010);
    rd("busy after byte3", 16'hf0e5, 8'hc0);
    poll();
    rd("addr step", 16'hf0e4, 8'h12);
    rd("byte0 only", 16'hf0e0, 8'h11);
    rd("no fetch", 16'hf0e5, 8'h80);
    rd("addr kept", 16'hf0e4, 8'h12);
    $display("test read done");
    end_of_test();
  end
endmodule
